// ---- ctm_chk_asserts.sv ----
// port-level checker for the edge-2 and current control block
`default_nettype none
module ctm_chk
  import ctm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [CTM_ADDR_W-1:0] paddr,
  input wire logic [CTM_DATA_W-1:0] prdata,
  input wire logic pready,
  // block side
  input wire logic adc_ten_bit_mode,
  input wire logic [CTM_SEL_W-1:0] edge2_source_select,
  input wire logic edge2_event_status,
  input wire logic [CTM_TRIM_W-1:0] current_trim_code,
  input wire logic [CTM_RNG_W-1:0] current_range_select,
  input wire logic current_source_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd0, rd4, wr0, wr4;
  // completing transfers, pready marks the one sampled edge
  assign rd0 = pready && !pwrite && paddr == CTM_ADDR_EDGE_CTRL2;
  assign rd4 = pready && !pwrite && paddr == CTM_ADDR_CURR_CTRL;
  assign wr0 = pready && pwrite && psel && paddr == CTM_ADDR_EDGE_CTRL2;
  assign wr4 = pready && pwrite && psel && paddr == CTM_ADDR_CURR_CTRL;
  property p_sel_rd; rd0 |-> prdata[5:0] == {edge2_source_select, 2'b00}; endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("select readback");
  // read data was captured one cycle before pready, and an event may set status between
  property p_stat_rd; rd0 |-> prdata[9] == $past(edge2_event_status); endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status readback");
  property p_trim_rd; rd4 |-> prdata[15:10] == current_trim_code; endproperty
  a_trim_rd: assert property (p_trim_rd) else $error("trim readback");
  property p_rng_rd; rd4 |-> prdata[9:8] == current_range_select; endproperty
  a_rng_rd: assert property (p_rng_rd) else $error("range readback");
  property p_low_zero; rd4 |-> prdata[7:0] == 8'h00; endproperty
  a_low_zero: assert property (p_low_zero) else $error("low byte not zero");
  // codes move only on a completing write
  property p_hold; !wr4 |=> $stable({current_trim_code, current_range_select}); endproperty
  a_hold: assert property (p_hold) else $error("codes moved");
  property p_en_off; !adc_ten_bit_mode [*8] |-> !current_source_enable; endproperty
  a_en_off: assert property (p_en_off) else $error("enable outside mode");
  property p_en_on; adc_ten_bit_mode [*8] |-> current_source_enable; endproperty
  a_en_on: assert property (p_en_on) else $error("enable missing");
  // reserved codes never raise the status
  property p_rsv;
    edge2_source_select inside {[4'h5:4'ha]} && !edge2_event_status && !wr0
      |=> !edge2_event_status;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code set status");
  c_evt: cover property ($rose(edge2_event_status));
  c_en: cover property ($rose(current_source_enable));
  c_wr4: cover property (wr4);
endmodule
bind ctm_edge_current ctm_chk ctm_chk_i (.pclk, .presetn, .psel, .pwrite, .paddr, .prdata,
  .pready, .adc_ten_bit_mode, .edge2_source_select, .edge2_event_status,
  .current_trim_code, .current_range_select, .current_source_enable);
`default_nettype wire

// ---- ctm_edge_current.sv ----
// edge-2 source selector and current source control with apb access
`default_nettype none
// Notes on behaviour
// - codes 1111..1011 pick instruction clock, osc pin, fast, backup, low-power rc
// - 0100..0001 pick comparator, pin b, pin a, output compare; 0101-1010 reserved
// - source select sits in bits 5:2; bits 1:0 read zero
// - trim bits 15:10 positive codes step +2% up to 011111 at +62%
// - trim codes with top bit set step -2% down, two's complement
// - range bits 9:8: 01 base, 10 ten, 11 hundred, 00 thousand times
// - edge-2 status set by selected event; software may also write it
// - current source enabled only while converter is in ten-bit mode
module ctm_edge_current
  import ctm_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CTM_ADDR_W-1:0] paddr,
  input wire logic [CTM_DATA_W-1:0] pwdata,
  input wire logic [CTM_STRB_W-1:0] pstrb,
  output logic [CTM_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // edge-2 trigger sources, asynchronous to pclk
  input wire logic instr_clock_in,
  input wire logic oscillator_input_pin,
  input wire logic fast_rc_oscillator,
  input wire logic backup_fast_rc_oscillator,
  input wire logic low_power_rc_oscillator,
  input wire logic comparator_unit_one,
  input wire logic edge_input_pin_b,
  input wire logic edge_input_pin_a,
  input wire logic output_compare_unit_one,
  // converter mode, high while the adc runs in ten-bit mode
  input wire logic adc_ten_bit_mode,
  // edge-2 controls toward the measurement core
  output logic [CTM_SEL_W-1:0] edge2_source_select,
  output logic edge2_event_status,
  // static codes toward the analog current source
  output logic [CTM_TRIM_W-1:0] current_trim_code,
  output logic [CTM_RNG_W-1:0] current_range_select,
  output logic current_source_enable
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [CTM_DATA_W-1:0] prdata;
    logic [CTM_SEL_W-1:0] sel;
    logic status;
    logic [CTM_TRIM_W-1:0] trim;
    logic [CTM_RNG_W-1:0] rng;
    logic enable;
    logic [CTM_NSRC-1:0] prev_level;
  } ctm_state_t;

  ctm_state_t st_reg;
  ctm_state_t st_next;

  // synchronised copies of every asynchronous input
  logic [CTM_NSYNC-1:0] raw_in;
  logic [CTM_NSYNC-1:0] sync_level;
  logic [CTM_NSRC-1:0] src_level;
  logic ten_bit_level;

  // decoded source index and edge detection
  logic [CTM_IDX_W-1:0] src_idx;
  logic src_valid;
  logic [CTM_NSRC-1:0] src_rise;
  logic edge2_event;

  // bus phase decode
  logic access;
  logic complete;
  logic hit_edge;
  logic hit_curr;
  logic hit_status;
  logic mapped;
  logic [CTM_DATA_W-1:0] read_word;

  // gather raw inputs into one vector for the synchroniser
  always_comb begin
    raw_in = '0;
    raw_in[CTM_IDX_OC1] = output_compare_unit_one;
    raw_in[CTM_IDX_PIN_A] = edge_input_pin_a;
    raw_in[CTM_IDX_PIN_B] = edge_input_pin_b;
    raw_in[CTM_IDX_COMPARATOR_UNIT_ONE] = comparator_unit_one;
    raw_in[CTM_IDX_LOW_POWER_RC_OSCILLATOR] = low_power_rc_oscillator;
    raw_in[CTM_IDX_BACKUP_FAST_RC_OSCILLATOR] = backup_fast_rc_oscillator;
    raw_in[CTM_IDX_FRC] = fast_rc_oscillator;
    raw_in[CTM_IDX_OSC_PIN] = oscillator_input_pin;
    raw_in[CTM_IDX_INSTR_CLK] = instr_clock_in;
    raw_in[CTM_IDX_TEN_BIT] = adc_ten_bit_mode;
  end

  // one shared synchroniser keeps all inputs on the same latency
  ctm_sync #(
    .W(CTM_NSYNC)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in),
    .level_out(sync_level)
  );

  assign src_level = sync_level[CTM_NSRC-1:0];
  assign ten_bit_level = sync_level[CTM_IDX_TEN_BIT];

  // source code to vector index; reserved codes select nothing
  always_comb begin
    src_idx = '0;
    src_valid = 1'b1;
    case (st_reg.sel)
      CTM_SRC_INSTR_CLK: src_idx = CTM_IDX_W'(CTM_IDX_INSTR_CLK);
      CTM_SRC_OSC_PIN: src_idx = CTM_IDX_W'(CTM_IDX_OSC_PIN);
      CTM_SRC_FRC: src_idx = CTM_IDX_W'(CTM_IDX_FRC);
      CTM_SRC_BACKUP_FAST_RC_OSCILLATOR: src_idx = CTM_IDX_W'(CTM_IDX_BACKUP_FAST_RC_OSCILLATOR);
      CTM_SRC_LOW_POWER_RC_OSCILLATOR: src_idx = CTM_IDX_W'(CTM_IDX_LOW_POWER_RC_OSCILLATOR);
      CTM_SRC_COMPARATOR_UNIT_ONE: src_idx = CTM_IDX_W'(CTM_IDX_COMPARATOR_UNIT_ONE);
      CTM_SRC_PIN_B: src_idx = CTM_IDX_W'(CTM_IDX_PIN_B);
      CTM_SRC_PIN_A: src_idx = CTM_IDX_W'(CTM_IDX_PIN_A);
      CTM_SRC_OC1: src_idx = CTM_IDX_W'(CTM_IDX_OC1);
      default: src_valid = 1'b0;
    endcase
  end

  // rising edge on every source, tracked all the time so that
  // switching the selector does not fake an edge
  assign src_rise = src_level & ~st_reg.prev_level;

  assign edge2_event = src_valid & src_rise[src_idx];

  // apb phase and address decode
  assign access = psel & penable;
  assign complete = access & st_reg.pready;
  assign hit_edge = (paddr == CTM_ADDR_EDGE_CTRL2);
  assign hit_curr = (paddr == CTM_ADDR_CURR_CTRL);
  assign hit_status = (paddr == CTM_ADDR_STATUS);
  assign mapped = hit_edge | hit_curr | hit_status;

  // read multiplexer; unlisted bits read zero
  always_comb begin
    read_word = '0;
    if (hit_edge) begin
      // select in 5:2, bits 1:0 stay zero
      read_word[CTM_SEL_MSB:CTM_SEL_LSB] = st_reg.sel;
      read_word[CTM_STAT_BIT] = st_reg.status;
    end else if (hit_curr) begin
      read_word[CTM_TRIM_MSB:CTM_TRIM_LSB] = st_reg.trim;
      read_word[CTM_RNG_MSB:CTM_RNG_LSB] = st_reg.rng;
    end else if (hit_status) begin
      read_word[CTM_ST_LEVEL_LSB +: CTM_NSRC] = src_level;
      read_word[CTM_ST_ENABLE_BIT] = st_reg.enable;
      read_word[CTM_ST_VALID_BIT] = src_valid;
    end
  end

  // next state: bus handshake, register writes, event capture
  always_comb begin
    st_next = st_reg;
    st_next.prev_level = src_level;

    // one wait state: pready rises in the second access cycle,
    // which lets prdata come from a flop like every other output
    if (access && !st_reg.pready) begin
      st_next.pready = 1'b1;
      st_next.pslverr = ~mapped;
      st_next.prdata = pwrite ? '0 : read_word;
    end else begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.prdata = '0;
    end

    // writes land only at the completing edge, per byte lane
    if (complete && pwrite && hit_edge) begin
      if (pstrb[CTM_LANE_LO]) begin
        st_next.sel = pwdata[CTM_SEL_MSB:CTM_SEL_LSB];
      end
      if (pstrb[CTM_LANE_HI]) begin
        st_next.status = pwdata[CTM_STAT_BIT];
      end
    end

    if (complete && pwrite && hit_curr && pstrb[CTM_LANE_HI]) begin
      // sign bit kept, two's complement steps
      st_next.trim = pwdata[CTM_TRIM_MSB:CTM_TRIM_LSB];
      st_next.rng = pwdata[CTM_RNG_MSB:CTM_RNG_LSB];
    end

    // hardware set beats a software clear
    if (edge2_event) begin
      st_next.status = 1'b1;
    end

    st_next.enable = ten_bit_level;
  end

  // single state register; everything clears on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.sel <= CTM_SEL_RESET;
      st_reg.trim <= CTM_TRIM_RESET;
      st_reg.rng <= CTM_RNG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // bus outputs straight from flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;

  // edge-2 controls
  assign edge2_source_select = st_reg.sel;
  assign edge2_event_status = st_reg.status;

  // static codes drive the analog source
  assign current_trim_code = st_reg.trim;
  assign current_range_select = st_reg.rng;
  assign current_source_enable = st_reg.enable;

endmodule
`default_nettype wire

// ---- ctm_edge_current_tb.sv ----
// self-checking bench for the edge-2 and current control block
`default_nettype none
module ctm_edge_current_tb
  import ctm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, sel;
  logic pready, pslverr, en, stat, err, adc;
  logic [5:0] trim;
  logic [1:0] rng;
  logic [8:0] src;
  int fail_count = 0, check_count = 0, cyc = 0;
  // 200 mhz clock
  always #2.5 pclk = ~pclk;
  ctm_src_model ctm_src_model_i (.pclk(pclk), .src(src), .adc_mode(adc));
  ctm_edge_current ctm_edge_current_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .instr_clock_in(src[8]),
    .oscillator_input_pin(src[7]), .fast_rc_oscillator(src[6]),
    .backup_fast_rc_oscillator(src[5]), .low_power_rc_oscillator(src[4]),
    .comparator_unit_one(src[3]), .edge_input_pin_b(src[2]), .edge_input_pin_a(src[1]),
    .output_compare_unit_one(src[0]), .adc_ten_bit_mode(adc), .edge2_source_select(sel),
    .edge2_event_status(stat), .current_trim_code(trim), .current_range_select(rng),
    .current_source_enable(en));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; returns at a falling edge so outputs are settled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken at the rising edge that sees pready high; hang guard ends a stuck wait
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic t_reset();
    apb(1'b0, CTM_ADDR_EDGE_CTRL2, 32'h0, rd, err);
    chk("ctrl2 reset", 32'h0, rd);
    apb(1'b0, CTM_ADDR_CURR_CTRL, 32'h0, rd, err);
    chk("current reset", 32'h0, rd);
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test reset done");
  endtask
  // every code, with bits 1:0 written high
  task automatic t_select();
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, CTM_ADDR_EDGE_CTRL2, {26'h0, i[3:0], 2'b11}, rd, err);
      apb(1'b0, CTM_ADDR_EDGE_CTRL2, 32'h0, rd, err);
      chk("select read", {26'h0, i[3:0], 2'b00}, rd);
      chk("select out", {28'h0, i[3:0]}, {28'h0, sel});
    end
    $display("test select done");
  endtask
  // reserved codes get every source fired and must stay quiet
  task automatic t_events();
    for (int c = 1; c < 16; c++) begin
      apb(1'b1, CTM_ADDR_EDGE_CTRL2, c << 2, rd, err);
      if (c > 4 && c < 11) for (int j = 0; j < 9; j++) ctm_src_model_i.fire(j);
      else ctm_src_model_i.fire(c < 5 ? c - 1 : c - 7);
      repeat (8) @(negedge pclk);
      chk("edge status", {31'h0, !(c > 4 && c < 11)}, {31'h0, stat});
    end
    // last event left status high, so clear it first to make the set visible
    apb(1'b1, CTM_ADDR_EDGE_CTRL2, 32'h0, rd, err);
    chk("status by clear", 32'h0, {31'h0, stat});
    apb(1'b1, CTM_ADDR_EDGE_CTRL2, 32'h200, rd, err);
    chk("status by write", 32'h1, {31'h0, stat});
    apb(1'b1, CTM_ADDR_EDGE_CTRL2, 32'h0, rd, err);
    $display("test events done");
  endtask
  // trim boundaries both signs, each range code, low byte written high
  task automatic t_current();
    logic [5:0] tv[6] = '{6'h01, 6'h1f, 6'h3f, 6'h22, 6'h02, 6'h3e};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, CTM_ADDR_CURR_CTRL, {16'h0, tv[i], i[1:0], 8'hff}, rd, err);
      apb(1'b0, CTM_ADDR_CURR_CTRL, 32'h0, rd, err);
      chk("current read", {16'h0, tv[i], i[1:0], 8'h00}, rd);
      chk("trim out", {26'h0, tv[i]}, {26'h0, trim});
      chk("range out", {30'h0, i[1:0]}, {30'h0, rng});
    end
    $display("test current done");
  endtask
  task automatic t_enable();
    ctm_src_model_i.set_mode(1'b1);
    repeat (10) @(negedge pclk);
    chk("enable on", 32'h1, {31'h0, en});
    ctm_src_model_i.set_mode(1'b0);
    repeat (10) @(negedge pclk);
    chk("enable off", 32'h0, {31'h0, en});
    $display("test enable done");
  endtask
  // reset for four cycles, then the scenarios
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_select();
    t_events();
    t_current();
    t_enable();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- ctm_pkg.sv ----
// shared constants for the edge-2 selector and current source control block
`default_nettype none
package ctm_pkg;
  // apb register byte addresses
  localparam logic [7:0] CTM_ADDR_EDGE_CTRL2 = 8'h00;
  localparam logic [7:0] CTM_ADDR_CURR_CTRL = 8'h04;
  localparam logic [7:0] CTM_ADDR_STATUS = 8'h08;
  localparam int CTM_ADDR_W = 8;
  localparam int CTM_DATA_W = 32;
  localparam int CTM_STRB_W = 4;

  // edge control register 2 layout
  localparam int CTM_SEL_LSB = 2;
  localparam int CTM_SEL_MSB = 5;
  localparam int CTM_SEL_W = 4;
  localparam int CTM_STAT_BIT = 9;

  // current source control register layout
  localparam int CTM_TRIM_LSB = 10;
  localparam int CTM_TRIM_MSB = 15;
  localparam int CTM_TRIM_W = 6;
  localparam int CTM_RNG_LSB = 8;
  localparam int CTM_RNG_MSB = 9;
  localparam int CTM_RNG_W = 2;

  // status register layout
  localparam int CTM_ST_LEVEL_LSB = 0;
  localparam int CTM_ST_ENABLE_BIT = 16;
  localparam int CTM_ST_VALID_BIT = 17;

  // byte lanes that carry each register half
  localparam int CTM_LANE_LO = 0;
  localparam int CTM_LANE_HI = 1;

  // reset values
  localparam logic [CTM_SEL_W-1:0] CTM_SEL_RESET = 4'h0;
  localparam logic [CTM_TRIM_W-1:0] CTM_TRIM_RESET = 6'h00;
  localparam logic [CTM_RNG_W-1:0] CTM_RNG_RESET = 2'h0;

  // edge-2 source codes
  localparam logic [CTM_SEL_W-1:0] CTM_SRC_INSTR_CLK = 4'hf;
  localparam logic [CTM_SEL_W-1:0] CTM_SRC_OSC_PIN = 4'he;
  localparam logic [CTM_SEL_W-1:0] CTM_SRC_FRC = 4'hd;
  localparam logic [CTM_SEL_W-1:0] CTM_SRC_BACKUP_FAST_RC_OSCILLATOR = 4'hc;
  localparam logic [CTM_SEL_W-1:0] CTM_SRC_LOW_POWER_RC_OSCILLATOR = 4'hb;
  localparam logic [CTM_SEL_W-1:0] CTM_SRC_COMPARATOR_UNIT_ONE = 4'h4;
  localparam logic [CTM_SEL_W-1:0] CTM_SRC_PIN_B = 4'h3;
  localparam logic [CTM_SEL_W-1:0] CTM_SRC_PIN_A = 4'h2;
  localparam logic [CTM_SEL_W-1:0] CTM_SRC_OC1 = 4'h1;

  // index of each trigger source in the synchronised source vector
  localparam int CTM_NSRC = 9;
  localparam int CTM_IDX_OC1 = 0;
  localparam int CTM_IDX_PIN_A = 1;
  localparam int CTM_IDX_PIN_B = 2;
  localparam int CTM_IDX_COMPARATOR_UNIT_ONE = 3;
  localparam int CTM_IDX_LOW_POWER_RC_OSCILLATOR = 4;
  localparam int CTM_IDX_BACKUP_FAST_RC_OSCILLATOR = 5;
  localparam int CTM_IDX_FRC = 6;
  localparam int CTM_IDX_OSC_PIN = 7;
  localparam int CTM_IDX_INSTR_CLK = 8;
  localparam int CTM_IDX_W = 4;
  // adc mode level rides on the synchroniser after the sources
  localparam int CTM_IDX_TEN_BIT = 9;
  localparam int CTM_NSYNC = 10;
endpackage
`default_nettype wire

// ---- ctm_src_model.sv ----
// trigger sources and converter mode that sit beside the block
`default_nettype none
module ctm_src_model (
  // bench clock, stimulus moves just after its rising edge
  input wire logic pclk,
  // trigger levels, index order of the package
  output logic [8:0] src,
  // converter mode level
  output logic adc_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // sources idle low, converter starts outside ten-bit mode
  initial begin
    src <= '0;
    adc_mode <= 1'b0;
  end
  // one source event
  // held well past the input filter so it is never lost
  task automatic fire(input int i);
    @(posedge pclk);
    src[i] <= 1'b1;
    repeat (12) @(posedge pclk);
    src[i] <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic set_mode(input logic v);
    @(posedge pclk);
    adc_mode <= v;
  endtask
endmodule
`default_nettype wire

// ---- ctm_sync.sv ----
// three-flop input synchroniser with agreement filter
`default_nettype none
module ctm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw inputs from outside the clock domain
  input wire logic [W-1:0] async_in,
  // filtered, synchronised levels
  output logic [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } ctm_sync_state_t;

  ctm_sync_state_t st_reg;
  ctm_sync_state_t st_next;

  // s1 only feeds s2; a bit moves once s2 and s3 agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.level = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s3)
                  | ((st_reg.s2 ^ st_reg.s3) & st_reg.level);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;
endmodule
`default_nettype wire
